// ---- epr_top.sv ----
// encoder position counter, p-regulator and encoder mode registers behind apb
//
// Chosen here: the APB slave port.
module epr_top
   import epr_pkg::*;
#(
   parameter int FILT_DIV0 = EPR_FILT_DIV0,
   parameter int FILT_DIV1 = EPR_FILT_DIV1,
   parameter int FILT_DIV2 = EPR_FILT_DIV2,
   parameter int FILT_DIV3 = EPR_FILT_DIV3,
   parameter int BLANK_UNIT = EPR_BLANK_UNIT
)
(
   // clock, reset, enable
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [EPR_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // encoder pins
   input wire logic enc_a,
   input wire logic enc_b,
   input wire logic enc_n,
   input wire logic bemf_cmp,
   // motion controller side, same clock
   input wire logic [31:0] ramp_position,
   input wire logic pos_reached,
   input wire logic full_step,
   input wire logic motor_dir_up,
   input wire logic quiescent,
   // results
   output logic [31:0] p_correction,
   output logic p_active,
   output logic index_event,
   output logic bemf_blanking,
   output logic decoder_enable,
   output logic [EPR_HYST_W-1:0] bemf_hyst
);
   // ****************************************
   // elaboration checks
   // ****************************************
   if (FILT_DIV0 < 2 || FILT_DIV0 >= (1 << EPR_FILT_W) ||
       FILT_DIV1 < 2 || FILT_DIV1 >= (1 << EPR_FILT_W) ||
       FILT_DIV2 < 2 || FILT_DIV2 >= (1 << EPR_FILT_W) ||
       FILT_DIV3 < 2 || FILT_DIV3 >= (1 << EPR_FILT_W)) begin : g_bad_div
      $error("filter divisor out of range");
   end
   if (BLANK_UNIT < 1 || BLANK_UNIT > EPR_BLANK_UNIT) begin : g_bad_blank
      $error("blank unit out of range");
   end

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      // software-visible registers, hidden fraction and clear arm
      logic [31:0] pctrl;
      logic [31:0] mode;
      logic [31:0] enc_const;
      logic [31:0] x_enc;
      logic [15:0] frac;
      logic clr_armed;
      // regulator result, decoder enable and bus answer
      logic [31:0] corr;
      logic p_act;
      logic dec_en;
      logic ready;
      logic err;
      logic [31:0] rdata;
   } epr_top_s;

   epr_top_s st_q, st_d;

   // decoder events
   logic q_step;
   logic q_up;
   logic q_idx;
   logic b_step;
   logic b_blank;

   // counter path
   logic cnt_step;
   logic cnt_up;
   logic [16:0] frac_base;
   logic [17:0] frac_sum;
   logic [31:0] inc;

   // regulator path
   logic signed [32:0] pos_err;
   logic [32:0] abs_err;
   logic signed [43:0] prod;
   logic ignore_err;

   // bus path
   logic acc_phase;
   logic wr_now;
   logic hit;
   logic [EPR_ADDR_W-1:0] a;
   logic [31:0] rd;

   // ****************************************
   // decoders
   // ****************************************
   epr_quad u_quad (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .pin_a(enc_a),
      .pin_b(enc_b),
      .pin_n(enc_n),
      .enable(st_q.dec_en && st_q.mode[EPR_SRC_BIT]),
      .pol_a(st_q.mode[EPR_POLA_BIT]),
      .pol_b(st_q.mode[EPR_POLB_BIT]),
      .pol_n(st_q.mode[EPR_POLN_BIT]),
      .skip_quadrature_match(st_q.mode[EPR_SKIP_BIT]),
      .n_sens(st_q.mode[EPR_SENS_LSB+:2]),
      .step(q_step),
      .dir_up(q_up),
      .index_event(q_idx)
   );

   epr_bemf #(
      .FILT_DIV0(FILT_DIV0),
      .FILT_DIV1(FILT_DIV1),
      .FILT_DIV2(FILT_DIV2),
      .FILT_DIV3(FILT_DIV3),
      .BLANK_UNIT(BLANK_UNIT)
   ) u_bemf (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .cmp_pin(bemf_cmp),
      .enable(st_q.dec_en && !st_q.mode[EPR_SRC_BIT]),
      .filt_sel(st_q.mode[EPR_FILT_LSB+:2]),
      .blank_time(st_q.mode[EPR_BLANK_LSB+:EPR_BLANK_W]),
      .blank_start(full_step),
      .step(b_step),
      .blanking(b_blank)
   );

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      st_d = st_q;

      // source select: back-emf steps follow the commanded direction
      cnt_step = st_q.mode[EPR_SRC_BIT] ? q_step : b_step;
      cnt_up = st_q.mode[EPR_SRC_BIT] ? q_up : motor_dir_up;
      st_d.dec_en = st_q.mode[EPR_QSC_BIT] || !quiescent;

      // fractional accumulation of the encoder constant per count
      frac_base = st_q.mode[EPR_DECI_BIT] ? EPR_FRAC_DEC : EPR_FRAC_BIN;
      inc = {16'h0, st_q.enc_const[31:16]};
      if (cnt_up) begin
         frac_sum = {2'h0, st_q.frac} + {2'h0, st_q.enc_const[15:0]};
         if (frac_sum >= {1'b0, frac_base}) begin
            frac_sum = frac_sum - {1'b0, frac_base};
            inc = inc + 32'h1;
         end
      end else begin
         frac_sum = {2'h0, st_q.frac} - {2'h0, st_q.enc_const[15:0]};
         if (frac_sum[17]) begin
            frac_sum = frac_sum + {1'b0, frac_base};
            inc = inc + 32'h1;
         end
      end
      if (cnt_step) begin
         st_d.frac = frac_sum[15:0];
         st_d.x_enc = cnt_up ? st_q.x_enc + inc : st_q.x_enc - inc;
      end

      // index clears the counter when enabled; once-mode disarms itself
      if (q_idx && st_q.mode[EPR_CLRX_BIT] &&
          (st_q.mode[EPR_CLRCONT_BIT] || st_q.clr_armed)) begin
         st_d.x_enc = EPR_XENC_RST;
         st_d.frac = '0;
         st_d.clr_armed = 1'b0;
      end

      // p-regulator
      pos_err = $signed({st_q.x_enc[31], st_q.x_enc}) -
         $signed({ramp_position[31], ramp_position});
      abs_err = pos_err[32] ? 33'(-pos_err) : 33'(pos_err);
      ignore_err = (abs_err < {25'h0, st_q.pctrl[EPR_TOL_LSB+:EPR_TOL_W]}) &&
         (!st_q.pctrl[EPR_TOLARR_BIT] || pos_reached);
      prod = 44'(pos_err) *
         44'($signed({1'b0, st_q.pctrl[EPR_P_LSB+:EPR_P_W]}));
      st_d.p_act = st_q.pctrl[EPR_P_LSB+:EPR_P_W] != '0;
      if (!st_d.p_act || ignore_err) begin
         st_d.corr = '0;
      end else if (prod > 44'sh0_7fff_ffff) begin
         st_d.corr = 32'h7fff_ffff;
      end else if (prod < -44'sh0_8000_0000) begin
         st_d.corr = 32'h8000_0000;
      end else begin
         st_d.corr = prod[31:0];
      end

      // apb: one wait state, read data lands with pready, write data on the edge that ends the ready cycle
      acc_phase = psel && penable;
      wr_now = acc_phase && st_q.ready && pwrite;
      a = paddr;
      hit = 1'b1;
      rd = '0;

      case (a)
         epr_byte_addr(EPR_IDX_PCTRL):
            rd = st_q.pctrl;
         epr_byte_addr(EPR_IDX_XENC):
            rd = st_q.x_enc;
         epr_byte_addr(EPR_IDX_MODE):
            rd = st_q.mode;
         epr_byte_addr(EPR_IDX_CONST):
            rd = st_q.enc_const;
         epr_byte_addr(EPR_IDX_STAT):
            rd = {29'h0, b_blank, st_q.dec_en, st_q.p_act};
         default: hit = 1'b0;
      endcase

      if (acc_phase && !st_q.ready) begin
         st_d.ready = 1'b1;
         // status is read-only: a write is answered with pslverr
         st_d.err = !hit ||
            (pwrite && a == epr_byte_addr(EPR_IDX_STAT));
         st_d.rdata = pwrite ? '0 : rd;
      end else begin
         st_d.ready = 1'b0;
         st_d.err = 1'b0;
         st_d.rdata = '0;
      end

      if (wr_now && !st_q.err) begin
         case (a)
            epr_byte_addr(EPR_IDX_PCTRL):
               st_d.pctrl = pwdata & EPR_PCTRL_MASK;
            epr_byte_addr(EPR_IDX_XENC): begin
               st_d.x_enc = pwdata;
               st_d.frac = '0;
            end
            epr_byte_addr(EPR_IDX_MODE): begin
               st_d.mode = pwdata & EPR_MODE_MASK;
               st_d.clr_armed = pwdata[EPR_CLRONCE_BIT];
            end
            epr_byte_addr(EPR_IDX_CONST):
               st_d.enc_const = pwdata;
            default: st_d.clr_armed = st_d.clr_armed;
         endcase
      end
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q <= '0;
         st_q.pctrl <= EPR_PCTRL_RST;
         st_q.mode <= EPR_MODE_RST;
         st_q.enc_const <= EPR_CONST_RST;
         st_q.x_enc <= EPR_XENC_RST;
         st_q.dec_en <= 1'b1;
      end else if (ce) begin
         st_q <= st_d;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   // idx and blank come straight from sub-module flops
   assign prdata = st_q.rdata;
   assign pready = st_q.ready;
   assign pslverr = st_q.err;

   assign p_correction = st_q.corr;
   assign p_active = st_q.p_act;

   assign index_event = q_idx;
   assign bemf_blanking = b_blank;
   assign decoder_enable = st_q.dec_en;
   assign bemf_hyst = st_q.mode[EPR_HYST_LSB+:EPR_HYST_W];
endmodule

// ---- epr_pkg.sv ----
// constants, register map and field layout of the encoder position regulator block
package epr_pkg;
   // ****************************************
   // register indices and byte addresses
   // ****************************************
   localparam logic [7:0] EPR_IDX_PCTRL = 8'h2d;
   localparam logic [7:0] EPR_IDX_XENC = 8'h2e;
   localparam logic [7:0] EPR_IDX_MODE = 8'h2f;
   localparam logic [7:0] EPR_IDX_CONST = 8'h30;
   localparam logic [7:0] EPR_IDX_STAT = 8'h31;
   localparam int EPR_ADDR_W = 10;
   function automatic logic [EPR_ADDR_W-1:0] epr_byte_addr(input logic [7:0] idx);
      return {idx, 2'h0};
   endfunction

   // ****************************************
   // position regulator control fields
   // ****************************************
   localparam int EPR_P_LSB = 0;
   localparam int EPR_P_W = 10;
   localparam int EPR_TOL_LSB = 16;
   localparam int EPR_TOL_W = 8;
   localparam int EPR_TOLARR_BIT = 28;
   localparam logic [31:0] EPR_PCTRL_MASK = 32'h10ff_03ff;
   localparam logic [31:0] EPR_PCTRL_RST = 32'h1000_0000;

   // ****************************************
   // encoder mode fields
   // ****************************************
   localparam int EPR_POLA_BIT = 0;
   localparam int EPR_POLB_BIT = 1;
   localparam int EPR_POLN_BIT = 2;
   localparam int EPR_SKIP_BIT = 3;
   localparam int EPR_CLRCONT_BIT = 4;
   localparam int EPR_CLRONCE_BIT = 5;
   localparam int EPR_SENS_LSB = 6;
   localparam int EPR_CLRX_BIT = 8;
   localparam int EPR_DECI_BIT = 10;
   localparam int EPR_SRC_BIT = 11;
   localparam int EPR_HYST_LSB = 12;
   localparam int EPR_HYST_W = 3;
   localparam int EPR_QSC_BIT = 15;
   localparam int EPR_BLANK_LSB = 16;
   localparam int EPR_BLANK_W = 8;
   localparam int EPR_FILT_LSB = 28;
   localparam logic [31:0] EPR_MODE_MASK = 32'h30ff_fdff;
   localparam logic [31:0] EPR_MODE_RST = 32'h0010_8000;

   // ****************************************
   // encoder constant and fraction bases
   // ****************************************
   localparam logic [31:0] EPR_CONST_RST = 32'h0001_0000;
   localparam logic [16:0] EPR_FRAC_BIN = 17'h1_0000;
   localparam logic [16:0] EPR_FRAC_DEC = 17'h0_2710;
   localparam logic [31:0] EPR_XENC_RST = 32'h0000_0000;

   // ****************************************
   // timing: back-emf filter divisors and blank unit, in clk periods
   // ****************************************
   localparam int EPR_FILT_DIV0 = 24600;
   localparam int EPR_FILT_DIV1 = 12300;
   localparam int EPR_FILT_DIV2 = 6150;
   localparam int EPR_FILT_DIV3 = 2870;
   localparam int EPR_BLANK_EXP = 14;
   localparam int EPR_BLANK_UNIT = (1 << EPR_BLANK_EXP) - 1;
   localparam int EPR_FILT_W = 15;
   localparam int EPR_BLANKCNT_W = 22;

   // index sensitivity codes
   typedef enum logic [1:0] {EPR_N_LEVEL, EPR_N_ACT_EDGE, EPR_N_INACT_EDGE, EPR_N_BOTH}
      epr_nsens_e;
endpackage

// ---- epr_quad.sv ----
// incremental abn decoder with pin synchronisers and index qualification
module epr_quad
   import epr_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // pins and control
   input wire logic pin_a,
   input wire logic pin_b,
   input wire logic pin_n,
   input wire logic enable,
   input wire logic pol_a,
   input wire logic pol_b,
   input wire logic pol_n,
   input wire logic skip_quadrature_match,
   input wire logic [1:0] n_sens,
   // decoded events
   output logic step,
   output logic dir_up,
   output logic index_event
);
   typedef struct packed {
      logic [2:0] s1;
      logic [2:0] s2;
      logic [2:0] s3;
      logic [2:0] stab;
      logic qual;
      logic step;
      logic dir_up;
      logic idx;
   } epr_quad_s;

   epr_quad_s st_q, st_d;
   logic qual_now;
   logic a_chg, b_chg;

   always_comb begin
      st_d = st_q;
      st_d.s1 = {pin_n, pin_b, pin_a};
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      // a change is only believed once the second and third stages agree
      for (int i = 0; i < 3; i++) begin
         if (st_q.s2[i] == st_q.s3[i]) begin
            st_d.stab[i] = st_q.s3[i];
         end
      end
      a_chg = st_d.stab[0] != st_q.stab[0];
      b_chg = st_d.stab[1] != st_q.stab[1];
      st_d.step = enable && (a_chg != b_chg);
      st_d.dir_up = st_d.stab[0] ^ st_q.stab[1];
      qual_now = (st_d.stab[2] == pol_n) &&
         (skip_quadrature_match || (st_d.stab[0] == pol_a && st_d.stab[1] == pol_b));
      st_d.qual = qual_now;
      case (epr_nsens_e'(n_sens))
         EPR_N_LEVEL: st_d.idx = qual_now;
         EPR_N_ACT_EDGE: st_d.idx = qual_now && !st_q.qual;
         EPR_N_INACT_EDGE: st_d.idx = !qual_now && st_q.qual;
         EPR_N_BOTH: st_d.idx = qual_now != st_q.qual;
         default: st_d.idx = 1'b0;
      endcase
      if (!enable) begin
         st_d.idx = 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q <= '0;
      end else if (ce) begin
         st_q <= st_d;
      end
   end

   assign step = st_q.step;
   assign dir_up = st_q.dir_up;
   assign index_event = st_q.idx;
endmodule

// ---- epr_bemf.sv ----
// back-emf comparator filter, blanking timer and full-step event source
module epr_bemf
   import epr_pkg::*;
#(
   parameter int FILT_DIV0 = EPR_FILT_DIV0,
   parameter int FILT_DIV1 = EPR_FILT_DIV1,
   parameter int FILT_DIV2 = EPR_FILT_DIV2,
   parameter int FILT_DIV3 = EPR_FILT_DIV3,
   parameter int BLANK_UNIT = EPR_BLANK_UNIT
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // comparator pin and control
   input wire logic cmp_pin,
   input wire logic enable,
   input wire logic [1:0] filt_sel,
   input wire logic [EPR_BLANK_W-1:0] blank_time,
   input wire logic blank_start,
   // results
   output logic step,
   output logic blanking
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic filt;
      logic [EPR_FILT_W-1:0] fcnt;
      logic [EPR_BLANKCNT_W-1:0] bcnt;
      logic step;
      logic blank;
   } epr_bemf_s;

   epr_bemf_s st_q, st_d;
   logic [EPR_FILT_W-1:0] div;

   function automatic logic [EPR_FILT_W-1:0] filt_div(input logic [1:0] sel);
      case (sel)
         2'h0: return EPR_FILT_W'(FILT_DIV0);
         2'h1: return EPR_FILT_W'(FILT_DIV1);
         2'h2: return EPR_FILT_W'(FILT_DIV2);
         default: return EPR_FILT_W'(FILT_DIV3);
      endcase
   endfunction

   always_comb begin
      st_d = st_q;
      st_d.s1 = cmp_pin;
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      st_d.step = 1'b0;
      div = filt_div(filt_sel);
      // low pass: the level must persist one divisor period before it is taken
      if (!enable || st_q.s2 != st_q.s3 || st_q.s3 == st_q.filt) begin
         st_d.fcnt = '0;
      end else if (st_q.fcnt >= div - EPR_FILT_W'(1)) begin
         st_d.fcnt = '0;
         st_d.filt = st_q.s3;
         st_d.step = (st_q.bcnt == '0);
      end else begin
         st_d.fcnt = st_q.fcnt + EPR_FILT_W'(1);
      end
      if (blank_start && enable) begin
         st_d.bcnt = EPR_BLANKCNT_W'(blank_time * BLANK_UNIT);
      end else if (st_q.bcnt != '0) begin
         st_d.bcnt = st_q.bcnt - EPR_BLANKCNT_W'(1);
      end
      // registered copy keeps the blanking output glitch free
      st_d.blank = st_d.bcnt != '0;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q <= '0;
      end else if (ce) begin
         st_q <= st_d;
      end
   end

   assign step = st_q.step;
   assign blanking = st_q.blank;
endmodule

// ---- epr_sva.sv ----
// assertion checker for the encoder position regulator block
module epr_sva
   import epr_pkg::*;
#(
   parameter int BLANK_UNIT = EPR_BLANK_UNIT
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [EPR_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // regulator and decoder
   input wire logic quiescent,
   input wire logic [31:0] p_correction,
   input wire logic p_active,
   input wire logic decoder_enable,
   input wire logic bemf_blanking
);
   // ****************************************
   // shadow of the mode register
   // ****************************************
   logic [31:0] mode_q;
   logic [31:0] blank_cnt_q;
   logic acc;
   logic [7:0] idx;
   logic qsc;
   assign acc = psel && penable && pready;
   assign idx = paddr[9:2];
   assign qsc = mode_q[EPR_QSC_BIT];
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mode_q <= 32'h0010_8000;
         blank_cnt_q <= 32'h0;
      end else begin
         if (acc && pwrite && !pslverr && idx == EPR_IDX_MODE) begin
            mode_q <= pwdata;
         end
         blank_cnt_q <= bemf_blanking ? blank_cnt_q + 32'h1 : 32'h0;
      end
   end
   // ****************************************
   // properties
   // ****************************************
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   property gain_p;
      logic v;
      (acc && pwrite && idx == EPR_IDX_PCTRL, v = (pwdata[9:0] != 10'h0)) |-> ##2 p_active == v;
   endproperty
   ready_wait_a: assert property (psel && penable && !pready |=> pready)
      else $error("pready missing after access");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   ready_hs_a: assert property (pready |-> psel && penable)
      else $error("pready outside access");
   rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
      else $error("prdata not zero outside answer");
   unmapped_err_a: assert property (acc && (idx < EPR_IDX_PCTRL || idx > EPR_IDX_STAT) |-> pslverr)
      else $error("unmapped access without pslverr");
   gain_enable_a: assert property (gain_p)
      else $error("p_active does not follow gain");
   gain_off_a: assert property (!p_active |-> p_correction == 32'h0)
      else $error("correction while regulator off");
   quiet_off_a: assert property ((quiescent && !qsc)[*2] |-> !decoder_enable)
      else $error("decoder on in gated quiescence");
   quiet_on_a: assert property ((!quiescent || qsc)[*2] |-> decoder_enable)
      else $error("decoder off while allowed");
   blank_len_a: assert property ($fell(bemf_blanking) |->
      blank_cnt_q == mode_q[23:16] * BLANK_UNIT)
      else $error("blank window length wrong");
   cover property (acc && pslverr);
   cover property ($fell(bemf_blanking));
   cover property (p_active && p_correction != 32'h0);
endmodule

bind epr_top epr_sva #(.BLANK_UNIT(BLANK_UNIT)) i_sva (.clk(clk), .rst(rst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .quiescent(quiescent), .p_correction(p_correction),
   .p_active(p_active), .decoder_enable(decoder_enable), .bemf_blanking(bemf_blanking));

// ---- epr_enc_model.sv ----
// quadrature, index and back-emf comparator model of the encoder side
module epr_enc_model
(
   // clock
   input wire logic clk,
   // encoder pins
   output logic enc_a,
   output logic enc_b,
   output logic enc_n,
   output logic bemf_cmp
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] ph = 2'h0;
   initial begin
      enc_a = 1'b0;
      enc_b = 1'b0;
      enc_n = 1'b0;
      bemf_cmp = 1'b0;
   end
   // gray order, one pin changes per step; held long past the synchronisers
   task automatic move(input int n, input logic up);
      repeat (n) begin
         ph = up ? ph + 2'h1 : ph - 2'h1;
         @(posedge clk);
         enc_a <= ph[1];
         enc_b <= ph[1] ^ ph[0];
         repeat (8) @(posedge clk);
      end
   endtask
   task automatic index_pulse();
      @(posedge clk);
      enc_n <= 1'b1;
      repeat (8) @(posedge clk);
      enc_n <= 1'b0;
      repeat (8) @(posedge clk);
   endtask
   // short excursion, then the return level is held well past any filter
   task automatic cmp_pulse(input int len);
      @(posedge clk);
      bemf_cmp <= ~bemf_cmp;
      repeat (len) @(posedge clk);
      bemf_cmp <= ~bemf_cmp;
      repeat (40) @(posedge clk);
   endtask
endmodule

// ---- epr_top_test.sv ----
// self-checking testbench of the encoder position regulator block
module epr_top_test
   import epr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int BU = 5;
   localparam logic [9:0] A_P = 10'h0b4;
   localparam logic [9:0] A_X = 10'h0b8;
   localparam logic [9:0] A_M = 10'h0bc;
   localparam logic [9:0] A_C = 10'h0c0;
   logic clk, rst, ce, psel, penable, pwrite, pos_reached, full_step, motor_dir_up, quiescent;
   logic [9:0] paddr;
   logic [2:0] bemf_hyst;
   logic [31:0] pwdata, ramp_position, prdata, p_correction, v;
   logic pready, pslverr, p_active, index_event, bemf_blanking, decoder_enable, seen, up_dir, e;
   logic enc_a, enc_b, enc_n, bemf_cmp;
   int failures = 0;
   int n_checks = 0;
   epr_top #(.FILT_DIV0(16), .FILT_DIV1(12), .FILT_DIV2(6), .FILT_DIV3(3), .BLANK_UNIT(BU))
   i_dut (.clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .enc_a(enc_a), .enc_b(enc_b), .enc_n(enc_n), .bemf_cmp(bemf_cmp),
      .ramp_position(ramp_position), .pos_reached(pos_reached), .full_step(full_step),
      .motor_dir_up(motor_dir_up), .quiescent(quiescent), .p_correction(p_correction),
      .p_active(p_active), .index_event(index_event), .bemf_blanking(bemf_blanking),
      .decoder_enable(decoder_enable), .bemf_hyst(bemf_hyst));
   epr_enc_model i_enc (.clk(clk), .enc_a(enc_a), .enc_b(enc_b), .enc_n(enc_n),
      .bemf_cmp(bemf_cmp));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) if (index_event === 1'b1) seen <= 1'b1;
   // ****************************************
   // bus and compare tasks
   // ****************************************
   task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic er);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      r = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [9:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic er;
      apb(1'b1, a, d, r, er);
   endtask
   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] got);
      n_checks++;
      if (got !== x) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", n, x, got);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_regs();
      apb(1'b0, A_P, 32'h0, v, e);
      chk("pctrl reset", 32'h1000_0000, v);
      apb(1'b0, A_M, 32'h0, v, e);
      chk("mode reset", 32'h0010_8000, v);
      chk("decoder_enable", 32'h1, {31'h0, decoder_enable});
      wr(A_P, 32'hffff_ffff);
      apb(1'b0, A_P, 32'h0, v, e);
      chk("pctrl fields", 32'h10ff_03ff, v);
      chk("p_active", 32'h1, {31'h0, p_active});
      wr(A_M, 32'hffff_ffff);
      apb(1'b0, A_M, 32'h0, v, e);
      chk("mode fields", 32'h30ff_fdff, v);
      chk("bemf_hyst", 32'h7, {29'h0, bemf_hyst});
      wr(A_M, 32'h0000_8000);
      apb(1'b0, 10'h3fc, 32'h0, v, e);
      chk("pslverr", 32'h1, {31'h0, e});
      wr(A_X, 32'd1000);
      apb(1'b0, A_X, 32'h0, v, e);
      chk("x_enc", 32'd1000, v);
   endtask
   task automatic pcase(input logic [9:0] p, input logic [7:0] tol, input logic arr,
                        input logic posr, input logic [31:0] ramp, input logic [31:0] x);
      @(posedge clk);
      ramp_position <= ramp;
      pos_reached <= posr;
      wr(A_P, {3'h0, arr, 4'h0, tol, 6'h0, p});
      repeat (4) @(posedge clk);
      chk("p_correction", x, p_correction);
   endtask
   task automatic t_freeze();
      pcase(10'h1, 8'h00, 1'b0, 1'b0, 32'd990, 32'ha);
      ce <= 1'b0;
      ramp_position <= 32'd1010;
      repeat (4) @(posedge clk);
      chk("p_correction frozen", 32'ha, p_correction);
      ce <= 1'b1;
      repeat (2) @(posedge clk);
      chk("p_correction resumed", 32'hffff_fff6, p_correction);
   endtask
   task automatic t_count();
      wr(A_M, 32'h0000_8800);
      wr(A_X, 32'd100);
      i_enc.move(4, 1'b1);
      apb(1'b0, A_X, 32'h0, v, e);
      up_dir = (v == 32'd104);
      chk("x_enc moved", 32'h1, {31'h0, v == 32'd104 || v == 32'd96});
      i_enc.move(4, 1'b0);
      apb(1'b0, A_X, 32'h0, v, e);
      chk("x_enc back", 32'd100, v);
      wr(A_M, 32'h0000_8000);
      i_enc.move(2, 1'b1);
      i_enc.move(2, 1'b0);
      apb(1'b0, A_X, 32'h0, v, e);
      chk("x_enc bemf src", 32'd100, v);
      wr(A_C, 32'h0000_1388);
      for (int m = 0; m < 2; m++) begin
         wr(A_M, m == 0 ? 32'h0000_8800 : 32'h0000_8c00);
         wr(A_X, 32'h0);
         i_enc.move(2, up_dir);
         apb(1'b0, A_X, 32'h0, v, e);
         chk("x_enc fraction", m, v);
      end
      wr(A_C, 32'h0001_0000);
   endtask
   task automatic t_index();
      wr(A_M, 32'h0000_8917);
      wr(A_X, 32'd50);
      i_enc.index_pulse();
      apb(1'b0, A_X, 32'h0, v, e);
      chk("x_enc no match", 32'd50, v);
      for (int s = 0; s < 4; s++) begin
         wr(A_M, 32'h0000_891f | (s << 6));
         wr(A_X, 32'd50);
         seen = 1'b0;
         i_enc.index_pulse();
         apb(1'b0, A_X, 32'h0, v, e);
         chk("x_enc index clear", 32'h0, v);
         chk("index_event", 32'h1, {31'h0, seen});
      end
   endtask
   task automatic t_quiet();
      @(posedge clk);
      quiescent <= 1'b1;
      wr(A_M, 32'h0000_0800);
      repeat (3) @(posedge clk);
      chk("decoder_enable gated", 32'h0, {31'h0, decoder_enable});
      wr(A_M, 32'h0000_8800);
      repeat (3) @(posedge clk);
      chk("decoder_enable kept", 32'h1, {31'h0, decoder_enable});
      quiescent <= 1'b0;
   endtask
   task automatic t_bemf();
      int n;
      for (int c = 0; c < 4; c++) begin
         wr(A_M, 32'h0000_8000 | (c << 28));
         wr(A_X, 32'h0);
         i_enc.cmp_pulse(9);
         apb(1'b0, A_X, 32'h0, v, e);
         chk("bemf counted", c >= 2, {31'h0, v != 32'h0});
      end
      wr(A_M, 32'h0002_8000);
      @(posedge clk);
      full_step <= 1'b1;
      @(posedge clk);
      full_step <= 1'b0;
      n = 0;
      repeat (40) begin
         @(posedge clk);
         if (bemf_blanking === 1'b1) n++;
      end
      chk("blank cycles", 2 * BU, n);
   endtask
   initial begin
      rst = 1'b1;
      {psel, penable, pwrite, pos_reached, full_step, quiescent, seen} = 7'h0;
      motor_dir_up = 1'b1;
      ce = 1'b1;
      paddr = 10'h0;
      pwdata = 32'h0;
      ramp_position = 32'h0;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      pcase(10'h1, 8'h05, 1'b0, 1'b0, 32'd997, 32'h0);
      pcase(10'h1, 8'h03, 1'b0, 1'b0, 32'd997, 32'h3);
      pcase(10'h1, 8'h05, 1'b1, 1'b0, 32'd997, 32'h3);
      pcase(10'h1, 8'h05, 1'b1, 1'b1, 32'd997, 32'h0);
      pcase(10'h3, 8'h00, 1'b0, 1'b0, 32'd1005, 32'hffff_fff1);
      pcase(10'h0, 8'h00, 1'b0, 1'b0, 32'd997, 32'h0);
      t_freeze();
      t_count();
      t_index();
      t_quiet();
      t_bemf();
      print_verdict();
   end
   initial begin
      repeat (50000) @(posedge clk);
      failures++;
      print_verdict();
   end
endmodule
